// ===== pic_pkg.sv
package pic_pkg;
   localparam int NSRC = 10;
   // maskable source slots, listed in default priority order
   localparam int S_TMR = 0;
   localparam int S_DMA0 = 1;
   localparam int S_DMA1 = 2;
   localparam int S_EXT0 = 3;
   localparam int S_EXT1 = 4;
   localparam int S_EXT4 = 7;
   localparam int S_WDOG = 8;
   localparam int S_SER = 9;
   localparam int LOW_LVL = 7;
   localparam logic [7:0] T_TMR0 = 8'h08;
   localparam logic [7:0] T_TMR1 = 8'h12;
   localparam logic [7:0] T_TMR2 = 8'h13;
   localparam logic [7:0] T_DMA0 = 8'h0A;
   localparam logic [7:0] T_DMA1 = 8'h0B;
   localparam logic [7:0] T_EXT0 = 8'h0C;
   localparam logic [7:0] T_EXT4 = 8'h10;
   localparam logic [7:0] T_WDOG = 8'h11;
   localparam logic [7:0] T_SER = 8'h14;
   localparam int EXC_NMI = 2;
   // slave-mode type codes, low three bits under the programmed base
   localparam logic [2:0] SC_TMR0 = 3'h0;
   localparam logic [2:0] SC_DMA0 = 3'h2;
   localparam logic [2:0] SC_DMA1 = 3'h3;
   localparam logic [2:0] SC_TMR1 = 3'h4;
   localparam logic [2:0] SC_TMR2 = 3'h5;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_PEND = 8'h08;
   localparam logic [7:0] OFS_INSV = 8'h0C;
   localparam logic [7:0] OFS_EOI = 8'h10;
   localparam logic [7:0] OFS_SBASE = 8'h14;
   localparam logic [7:0] OFS_EVST = 8'h18;
   localparam logic [7:0] OFS_EVMSK = 8'h1C;
   localparam int CTRL_SLAVE = 0;
   localparam int CTRL_SFNM0 = 1;
   localparam int CTRL_SFNM1 = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [9:0] MASK_RST = 10'h000;
   localparam logic [4:0] SBASE_RST = 5'h00;
   localparam int EV_NMI = 0;
   localparam int EV_BADEOI = 1;
   localparam int EV_EXC = 2;
   localparam logic [2:0] EVMSK_RST = 3'h0;
   typedef struct packed {
      logic valid;
      logic [7:0] vtype;
   } pic_core_req_t;
endpackage

// ===== pic_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [R1] five external maskable lines, nmi, three timers, two dma, serial port
// [R2] pending requests are ranked and offered to the core one at a time
// [R3] each external line is a direct request; lines 0-3 may cascade (no cascade mode is built here, all five lines are direct requests only)
// [R4] slave mode lets an external master controller drive the system
// [R5] higher priority requests nest over lower ones in every mode
// [R6] acceptance blocks maskable requests until the core sets its enable flag
// [R7] a source in service is blocked until its in-service bit clears
// [R8] special nesting on lines 0 and 1 ignores their in-service bit
// [R9] exceptions take types 00h-07h, top priority, vector is type times four
// [R10] trace is type 01h, then nmi type 02h at vector 08h
// [R11] timers share one request and slot, types 08h 12h 13h, eoi 08h
// [R12] timer 0 ranks over timer 1, timer 1 over timer 2
// [R13] dma and lines 0-3 use types 0ah-0fh, eoi equals type
// [R14] line 4, watchdog and serial sit at lowest level, own eoi types
// [R15] line 4, watchdog and serial are unavailable in slave mode
// [R16] slave mode makes timer and dma types programmable
// [R17] sources arbitrate at their default priority levels
// [R18] escape opcode trap is vectored as type 07h
// [R19] eoi with a source's type clears its in-service bit
module pic_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] ext_irq_pin,
   input wire logic nmi_pin,
   input wire logic [2:0] timer_evt,
   input wire logic [1:0] dma_evt,
   input wire logic wdog_evt,
   input wire logic serial_evt,
   input wire logic [7:0] exc_evt,
   input wire logic core_if,
   input wire logic core_ack,
   output pic_pkg::pic_core_req_t core_req,
   output logic [9:0] vec_addr,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   logic [5:0] sync1_reg, sync2_reg, sync3_reg;
   logic [2:0] ctrl_reg;
   logic [9:0] mask_reg, pend_reg, insv_reg;
   logic [2:0] tmr_pend_reg;
   logic [7:0] exc_reg;
   logic [4:0] sbase_reg;
   logic [2:0] evst_reg, evmsk_reg;
   logic [3:0] sel_reg;
   logic sel_exc_reg, hold_reg;
   logic [1:0] tsel_reg;
   logic [2:0] esel_reg;
   logic [31:0] rdata;
   logic mapped;
   logic wr_acc, rd_acc;
   logic [5:0] rise;
   logic [9:0] evt_in, avail, elig;
   logic [3:0] cur_lvl, win;
   logic win_ok;
   logic [1:0] tsel;
   logic [2:0] esel;
   logic [7:0] win_type;
   logic take;
   logic [9:0] eoi_hit;
   logic slave;

   assign slave = ctrl_reg[pic_pkg::CTRL_SLAVE];
   assign wr_acc = psel & penable & pready & pwrite;
   assign rd_acc = psel & penable & pready & ~pwrite;
   assign take = core_ack & core_req.valid;

   function automatic logic [3:0] lvl(input int i);
      lvl = (i < pic_pkg::LOW_LVL) ? 4'(i) : 4'(pic_pkg::LOW_LVL); // [R14] [R17]
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pins from outside; stage one feeds stage two only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
         sync3_reg <= 6'h00;
      end else begin
         sync1_reg <= {nmi_pin, ext_irq_pin};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   assign rise = sync2_reg & ~sync3_reg;

   // [R1] every maskable source lands in its own pending slot, except the three timers, which share slot 0
   assign evt_in = {serial_evt, wdog_evt, rise[4], rise[3:0], dma_evt,
                    |timer_evt};

   ////////////////////////////////////////////////////////////////////
   // availability and blocking
   always_comb begin
      avail = ~mask_reg;
      if (slave) begin
         avail[pic_pkg::S_EXT4] = 1'b0; // [R15]
         avail[pic_pkg::S_WDOG] = 1'b0; // [R15]
         avail[pic_pkg::S_SER] = 1'b0; // [R15]
      end
   end

   // lowest level number currently in service, 8 when idle
   always_comb begin
      cur_lvl = 4'h8;
      for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
         if (insv_reg[i]) begin
            cur_lvl = lvl(i);
         end
      end
   end

   always_comb begin
      for (int i = 0; i < pic_pkg::NSRC; i++) begin
         // equal level may preempt, a lower one may not [R5] [R6]
         elig[i] = pend_reg[i] & avail[i] & (lvl(i) <= cur_lvl)
                   & ~insv_reg[i]; // [R7]
      end
      if (ctrl_reg[pic_pkg::CTRL_SFNM0]) begin
         elig[pic_pkg::S_EXT0] = pend_reg[pic_pkg::S_EXT0]
            & avail[pic_pkg::S_EXT0] & (lvl(pic_pkg::S_EXT0) <= cur_lvl); // [R8]
      end
      if (ctrl_reg[pic_pkg::CTRL_SFNM1]) begin
         elig[pic_pkg::S_EXT1] = pend_reg[pic_pkg::S_EXT1]
            & avail[pic_pkg::S_EXT1] & (lvl(pic_pkg::S_EXT1) <= cur_lvl); // [R8]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // arbitration: slot index order is the default ranking
   always_comb begin
      win = 4'h0;
      win_ok = 1'b0;
      for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            win = 4'(i); // [R2] [R17]
            win_ok = 1'b1;
         end
      end
   end

   // timer sub-ranking inside the shared slot
   always_comb begin
      if (tmr_pend_reg[0]) begin
         tsel = 2'd0; // [R12]
      end else if (tmr_pend_reg[1]) begin
         tsel = 2'd1; // [R12]
      end else begin
         tsel = 2'd2;
      end
   end

   // instruction faults first, then trace, then nmi
   always_comb begin
      esel = 3'd2;
      if (exc_reg[1]) begin
         esel = 3'd1; // [R10]
      end
      for (int i = 7; i >= 3; i--) begin
         if (exc_reg[i]) begin
            esel = 3'(i); // [R9] [R18]
         end
      end
      if (exc_reg[0]) begin
         esel = 3'd0; // [R9]
      end
   end

   always_comb begin
      win_type = pic_pkg::T_EXT0 + {4'h0, win} - 8'h03; // [R13] [R3]
      case (win)
         4'd0: begin
            if (slave) begin
               win_type = {sbase_reg, (tsel == 2'd0) ? pic_pkg::SC_TMR0 :
                  (tsel == 2'd1) ? pic_pkg::SC_TMR1 : pic_pkg::SC_TMR2}; // [R16]
            end else begin
               win_type = (tsel == 2'd0) ? pic_pkg::T_TMR0 :
                  (tsel == 2'd1) ? pic_pkg::T_TMR1 : pic_pkg::T_TMR2; // [R11]
            end
         end
         4'd1: win_type = slave ? {sbase_reg, pic_pkg::SC_DMA0} :
            pic_pkg::T_DMA0; // [R13] [R16]
         4'd2: win_type = slave ? {sbase_reg, pic_pkg::SC_DMA1} :
            pic_pkg::T_DMA1; // [R13] [R16]
         4'd7: win_type = pic_pkg::T_EXT4; // [R14]
         4'd8: win_type = pic_pkg::T_WDOG; // [R14]
         4'd9: win_type = pic_pkg::T_SER; // [R14]
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // offer to the core; registered so the ack refers to a stable choice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_req <= '0;
         vec_addr <= 10'h000;
         sel_reg <= 4'h0;
         sel_exc_reg <= 1'b0;
         tsel_reg <= 2'd0;
         esel_reg <= 3'd0;
      end else begin
         if (|exc_reg) begin
            // exceptions and nmi ignore the enable flag
            core_req.valid <= ~hold_reg & ~take;
            core_req.vtype <= {5'h00, esel};
            vec_addr <= {5'h00, esel, 2'b00}; // [R9] [R10]
            sel_exc_reg <= 1'b1;
         end else begin
            core_req.valid <= win_ok & core_if & ~hold_reg & ~take; // [R6]
            core_req.vtype <= win_type;
            vec_addr <= {win_type, 2'b00}; // [R9]
            sel_exc_reg <= 1'b0;
         end
         sel_reg <= win;
         tsel_reg <= tsel;
         esel_reg <= esel;
      end
   end

   // after an accept nothing more is offered until the core drops its flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= 1'b0;
      end else if (take) begin
         hold_reg <= 1'b1; // [R6]
      end else if (!core_if) begin
         hold_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pending latches; a new event beats the clear of an accept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 10'h000;
         tmr_pend_reg <= 3'h0;
         exc_reg <= 8'h00;
      end else begin
         for (int i = 0; i < pic_pkg::NSRC; i++) begin
            if (evt_in[i]) begin
               pend_reg[i] <= 1'b1;
            end else if (i == pic_pkg::S_TMR) begin
               pend_reg[i] <= |(tmr_pend_reg & ~((take & ~sel_exc_reg
                  & sel_reg == 4'h0) ? (3'h1 << tsel_reg) : 3'h0)); // [R11]
            end else if (take && !sel_exc_reg && sel_reg == 4'(i)) begin
               pend_reg[i] <= 1'b0;
            end
         end
         for (int t = 0; t < 3; t++) begin
            if (timer_evt[t]) begin
               tmr_pend_reg[t] <= 1'b1;
            end else if (take && !sel_exc_reg && sel_reg == 4'h0
                         && tsel_reg == 2'(t)) begin
               tmr_pend_reg[t] <= 1'b0;
            end
         end
         for (int e = 0; e < 8; e++) begin
            if (exc_evt[e] || (e == pic_pkg::EXC_NMI && rise[5])) begin
               exc_reg[e] <= 1'b1; // [R10]
            end else if (take && sel_exc_reg && esel_reg == 3'(e)) begin
               exc_reg[e] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // eoi decode; exceptions have no eoi type
   always_comb begin
      eoi_hit = 10'h000;
      case (pwdata[7:0])
         pic_pkg::T_TMR0: eoi_hit[pic_pkg::S_TMR] = ~slave; // [R11]
         pic_pkg::T_DMA0: eoi_hit[pic_pkg::S_DMA0] = ~slave;
         pic_pkg::T_DMA1: eoi_hit[pic_pkg::S_DMA1] = ~slave;
         pic_pkg::T_EXT4: eoi_hit[pic_pkg::S_EXT4] = 1'b1; // [R14]
         pic_pkg::T_WDOG: eoi_hit[pic_pkg::S_WDOG] = 1'b1;
         pic_pkg::T_SER: eoi_hit[pic_pkg::S_SER] = 1'b1;
         default: ;
      endcase
      for (int i = 3; i < 7; i++) begin
         if (pwdata[7:0] == pic_pkg::T_EXT0 + 8'(i - 3)) begin
            eoi_hit[i] = 1'b1; // [R13]
         end
      end
      if (slave && pwdata[7:3] == sbase_reg) begin
         eoi_hit[pic_pkg::S_TMR] = (pwdata[2:0] == pic_pkg::SC_TMR0); // [R16]
         eoi_hit[pic_pkg::S_DMA0] = (pwdata[2:0] == pic_pkg::SC_DMA0);
         eoi_hit[pic_pkg::S_DMA1] = (pwdata[2:0] == pic_pkg::SC_DMA1);
      end
   end

   // accept sets a bit, eoi clears it; accept wins on the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         insv_reg <= 10'h000;
      end else begin
         for (int i = 0; i < pic_pkg::NSRC; i++) begin
            if (take && !sel_exc_reg && sel_reg == 4'(i)) begin
               insv_reg[i] <= 1'b1; // [R7]
            end else if (wr_acc && paddr == pic_pkg::OFS_EOI && eoi_hit[i]) begin
               insv_reg[i] <= 1'b0; // [R19]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata <= (psel & ~penable & ~pwrite) ? rdata : 32'h0000_0000;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         pic_pkg::OFS_CTRL: rdata[2:0] = ctrl_reg;
         pic_pkg::OFS_MASK: rdata[9:0] = mask_reg;
         pic_pkg::OFS_PEND: rdata[9:0] = pend_reg;
         pic_pkg::OFS_INSV: rdata[9:0] = insv_reg;
         pic_pkg::OFS_EOI: ;
         pic_pkg::OFS_SBASE: rdata[4:0] = sbase_reg;
         pic_pkg::OFS_EVST: rdata[2:0] = evst_reg;
         pic_pkg::OFS_EVMSK: rdata[2:0] = evmsk_reg;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= pic_pkg::CTRL_RST;
         mask_reg <= pic_pkg::MASK_RST;
         sbase_reg <= pic_pkg::SBASE_RST;
         evmsk_reg <= pic_pkg::EVMSK_RST;
      end else if (wr_acc) begin
         case (paddr)
            pic_pkg::OFS_CTRL: ctrl_reg <= pwdata[2:0]; // [R4]
            pic_pkg::OFS_MASK: mask_reg <= pwdata[9:0];
            pic_pkg::OFS_SBASE: sbase_reg <= pwdata[4:0];
            pic_pkg::OFS_EVMSK: evmsk_reg <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event status, cleared by read; a same-cycle event survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evst_reg <= 3'h0;
      end else begin
         evst_reg <= ((rd_acc && paddr == pic_pkg::OFS_EVST) ? 3'h0 : evst_reg)
            | {take & sel_exc_reg,
               wr_acc & (paddr == pic_pkg::OFS_EOI) & ~(|(eoi_hit & insv_reg)),
               rise[5]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evst_reg & evmsk_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_setup;
      psel && !penable;
   endsequence
   property p_apb_ready;
      @(posedge pclk) disable iff (!presetn) s_setup |=> pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

   property p_accept_drops;
      @(posedge pclk) disable iff (!presetn)
         take |=> !core_req.valid [*2];
   endproperty
   a_accept_drops: assert property (p_accept_drops) // [R6]
      else $error("request held after accept");

   property p_insv_set;
      @(posedge pclk) disable iff (!presetn)
         take && !sel_exc_reg |=> insv_reg[$past(sel_reg)];
   endproperty
   a_insv_set: assert property (p_insv_set) // [R7]
      else $error("in-service bit not set");

   property p_eoi_clear;
      @(posedge pclk) disable iff (!presetn)
         wr_acc && paddr == pic_pkg::OFS_EOI && pwdata[7:0] == 8'h0D && !take
         |=> !insv_reg[pic_pkg::S_EXT1];
   endproperty
   a_eoi_clear: assert property (p_eoi_clear) // [R19]
      else $error("eoi did not clear line 1");

   property p_slave_off;
      @(posedge pclk) disable iff (!presetn)
         core_req.valid && $past(slave) |->
         core_req.vtype != pic_pkg::T_EXT4 && core_req.vtype != pic_pkg::T_SER;
   endproperty
   a_slave_off: assert property (p_slave_off) // [R15]
      else $error("unavailable source offered in slave mode");

   property p_if_gate;
      @(posedge pclk) disable iff (!presetn)
         core_req.valid && core_req.vtype > 8'h07 |-> $past(core_if);
   endproperty
   a_if_gate: assert property (p_if_gate) // [R6]
      else $error("maskable request with flag clear");

   property p_block;
      @(posedge pclk) disable iff (!presetn)
         core_req.valid && core_req.vtype == 8'h0E |-> !$past(insv_reg[5]);
   endproperty
   a_block: assert property (p_block) // [R7]
      else $error("source offered while in service");

   property p_vec;
      @(posedge pclk) disable iff (!presetn)
         core_req.valid |-> vec_addr == {core_req.vtype, 2'b00};
   endproperty
   a_vec: assert property (p_vec) // [R9]
      else $error("vector address not four times type");

   property p_nmi_type;
      @(posedge pclk) disable iff (!presetn)
         core_req.valid && $past(exc_reg) == 8'h04 |-> core_req.vtype == 8'h02;
   endproperty
   a_nmi_type: assert property (p_nmi_type) // [R10]
      else $error("nmi type wrong");
endmodule // pic_ctrl
`default_nettype wire

// ===== pic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire pic_pkg::pic_core_req_t core_req,
   input wire logic [3:0] lat,
   input wire logic set_if,
   output logic core_ack,
   output logic core_if
);
   logic [3:0] wait_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // accept after lat+1 cycles of a standing offer; ack lasts one cycle only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (core_ack) begin
         core_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (core_req.valid) begin
         core_ack <= (wait_cnt == lat);
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         wait_cnt <= 4'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // acceptance clears the enable flag; the service routine sets it again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_if <= 1'b0;
      end else if (core_ack) begin
         core_if <= 1'b0;
      end else if (set_if) begin
         core_if <= 1'b1;
      end
   end
endmodule // pic_core_model
`default_nettype wire

// ===== prioritized_interrupt_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_controller_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, nmi_pin = 1'b0, wdog_evt = 1'b0, serial_evt = 1'b0;
   logic [4:0] ext_irq_pin = 5'h00;
   logic [2:0] timer_evt = 3'h0;
   logic [1:0] dma_evt = 2'h0;
   logic [7:0] exc_evt = 8'h00;
   logic core_if, core_ack, irq, set_if = 1'b0;
   logic [3:0] lat = 4'h0;
   pic_pkg::pic_core_req_t core_req;
   logic [9:0] vec_addr;
   logic [17:0] q[$];
   int fail_count = 0, tests_run = 0;
   localparam logic [11:0][7:0] EXP = {8'h14, 8'h11, 8'h10, 8'h0F, 8'h0E, 8'h0D,
      8'h0C, 8'h0B, 8'h0A, 8'h13, 8'h12, 8'h08};
   always #4 pclk = ~pclk;
   pic_ctrl i_pic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .nmi_pin(nmi_pin), .timer_evt(timer_evt),
      .dma_evt(dma_evt), .wdog_evt(wdog_evt), .serial_evt(serial_evt), .exc_evt(exc_evt),
      .core_if(core_if), .core_ack(core_ack), .core_req(core_req), .vec_addr(vec_addr),
      .irq(irq));
   pic_core_model i_pic_core_model (.pclk(pclk), .presetn(presetn), .core_req(core_req),
      .lat(lat), .set_if(set_if), .core_ack(core_ack), .core_if(core_if));
   // log what the core took, vector beside type
   always @(posedge pclk) begin
      if (core_ack && core_req.valid) begin
         q.push_back({vec_addr, core_req.vtype});
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         fail_count++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic e;
      apb(1'b0, a, 32'h0, rd, e);
      chk(rd, exp);
      chk_bit(e, experr);
   endtask
   task automatic fire(input logic [12:0] m, input logic [7:0] e);
      @(posedge pclk);
      timer_evt <= m[2:0];
      dma_evt <= m[4:3];
      ext_irq_pin <= m[9:5];
      wdog_evt <= m[10];
      serial_evt <= m[11];
      nmi_pin <= m[12];
      exc_evt <= e;
      @(posedge pclk);
      timer_evt <= 3'h0;
      dma_evt <= 2'h0;
      wdog_evt <= 1'b0;
      serial_evt <= 1'b0;
      exc_evt <= 8'h00;
      // pins pass a two-flop synchroniser, so hold them a few edges
      repeat (3) @(posedge pclk);
      ext_irq_pin <= 5'h00;
      nmi_pin <= 1'b0;
   endtask
   task automatic pulse_if();
      @(posedge pclk);
      set_if <= 1'b1;
      @(posedge pclk);
      set_if <= 1'b0;
   endtask
   task automatic take(input logic [7:0] t);
      int k;
      logic [17:0] v;
      k = 0;
      while (q.size() == 0 && k < 300) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 300) begin
         fail_count++;
         end_sim();
      end
      v = q.pop_front();
      chk({24'h0, v[7:0]}, {24'h0, t});
      chk({22'h0, v[17:8]}, {22'h0, t, 2'b00});
   endtask
   task automatic serve(input logic [7:0] t, input logic [7:0] eoi);
      take(t);
      wr(pic_pkg::OFS_EOI, {24'h0, eoi});
      pulse_if();
   endtask
   task automatic quiet(input int n);
      repeat (n) @(posedge pclk);
      chk(q.size(), 32'h0);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(pic_pkg::OFS_CTRL, 32'h0, 1'b0);
      rdc(pic_pkg::OFS_MASK, 32'h0, 1'b0);
      rdc(pic_pkg::OFS_SBASE, 32'h0, 1'b0);
      rdc(pic_pkg::OFS_EVMSK, 32'h0, 1'b0);
      rdc(pic_pkg::OFS_INSV, 32'h0, 1'b0);
      rdc(8'h20, 32'h0, 1'b1);
      wr(pic_pkg::OFS_MASK, 32'h3FF);
      rdc(pic_pkg::OFS_MASK, 32'h3FF, 1'b0);
      wr(pic_pkg::OFS_MASK, 32'h0);
      wr(pic_pkg::OFS_PEND, 32'hFF);
      rdc(pic_pkg::OFS_PEND, 32'h0, 1'b0);
      done("registers");
      pulse_if();
      fire(13'h007, 8'h00);
      take(8'h08);
      pulse_if();
      quiet(20);
      wr(pic_pkg::OFS_EOI, 32'h08);
      serve(8'h12, 8'h08);
      serve(8'h13, 8'h08);
      done("timers");
      lat <= 4'h5;
      for (int i = 3; i < 12; i++) begin
         fire(13'h1 << i, 8'h00);
         serve(EXP[i], EXP[i]);
      end
      lat <= 4'h0;
      done("types");
      fire(13'h03C, 8'h00);
      serve(8'h13, 8'h08);
      serve(8'h0A, 8'h0A);
      serve(8'h0B, 8'h0B);
      serve(8'h0C, 8'h0C);
      fire(13'h100, 8'h00);
      take(8'h0F);
      pulse_if();
      fire(13'h008, 8'h00);
      serve(8'h0A, 8'h0A);
      wr(pic_pkg::OFS_EOI, 32'h0F);
      done("priority");
      wr(pic_pkg::OFS_CTRL, 32'h2);
      fire(13'h020, 8'h00);
      take(8'h0C);
      pulse_if();
      fire(13'h020, 8'h00);
      serve(8'h0C, 8'h0C);
      fire(13'h040, 8'h00);
      take(8'h0D);
      pulse_if();
      fire(13'h040, 8'h00);
      quiet(20);
      wr(pic_pkg::OFS_EOI, 32'h0D);
      serve(8'h0D, 8'h0D);
      wr(pic_pkg::OFS_CTRL, 32'h0);
      done("nesting");
      fire(13'h1001, 8'h83);
      take(8'h00);
      take(8'h07);
      take(8'h01);
      take(8'h02);
      pulse_if();
      serve(8'h08, 8'h08);
      done("exceptions");
      wr(pic_pkg::OFS_EVMSK, 32'h0);
      wr(pic_pkg::OFS_EVST, 32'h0);
      wr(pic_pkg::OFS_EOI, 32'h0C);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b0);
      wr(pic_pkg::OFS_EVMSK, 32'h2);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b1);
      // nmi edge and exception accepts are still latched from earlier tests
      rdc(pic_pkg::OFS_EVST, 32'h7, 1'b0);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b0);
      done("irq");
      wr(pic_pkg::OFS_SBASE, 32'h05);
      wr(pic_pkg::OFS_CTRL, 32'h1);
      fire(13'h200, 8'h00);
      quiet(30);
      fire(13'h001, 8'h00);
      take(8'h28);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(pic_pkg::OFS_CTRL, 32'h0, 1'b0);
      done("slave");
      end_sim();
   end
endmodule // prioritized_interrupt_controller_tb
`default_nettype wire
